// ---- rtl/bit_flag_instr_exec.sv ----
// Purpose: executes bit transfer, I/O bit, rotate, flag, sleep and
//          watchdog-restart operations issued through the command register
// Assumes: bus master on the same clock; single word transfers only
// Notes: the working and I/O register files live here as flip-flops
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module bit_flag_instr_exec #(
    parameter int NUM_WREGS = 32,
    parameter int NUM_IOREGS = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register bus
    input wire bitexec_pkg::ahb_in_s bus_i,
    output bitexec_pkg::ahb_out_s bus_o,
    // core side events
    output logic busy_o,
    output logic sleep_req_o,
    output logic wdog_restart_o,
    output logic [7:0] status_o
);
    localparam int WIDX = $clog2(NUM_WREGS);
    localparam int PIDX = $clog2(NUM_IOREGS);

    typedef struct packed {
        bitexec_pkg::exec_e st;
        logic [1:0] cnt;
        bitexec_pkg::op_e op;
        logic [WIDX-1:0] ridx;
        logic [2:0] bsel;
        logic [PIDX-1:0] pidx;
        logic [7:0] flags;
        logic [NUM_WREGS-1:0][7:0] wreg;
        logic [NUM_IOREGS-1:0][7:0] ioreg;
        logic [WIDX-1:0] sel_w;
        logic [PIDX-1:0] sel_io;
        logic [7:0] wdog_cnt;
        logic overrun;
        logic busy;
        logic sleep_pulse;
        logic wdog_pulse;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic rd_pend;
        logic [31:0] hrdata;
        logic hready;
        logic [31:0] last_cmd;
    } state_s;

    state_s s_reg;
    state_s s_next;

    // length of each operation in core cycles
    function automatic logic [1:0] op_cycles(input bitexec_pkg::op_e op);
        case (op)
            bitexec_pkg::io_bit_set_op: op_cycles = bitexec_pkg::CYC_IO;
            bitexec_pkg::io_bit_clear_op: op_cycles = bitexec_pkg::CYC_IO;
            bitexec_pkg::sleep_op: op_cycles = bitexec_pkg::CYC_SLEEP;
            default: op_cycles = bitexec_pkg::CYC_ONE;
        endcase
    endfunction

    // next state: bus writes first, then execution, so a completing
    // operation wins over a software write to the same flag or register
    always_comb begin
        logic [7:0] w;
        logic [7:0] res;
        logic [31:0] rd;
        logic [31:0] wd;
        w = s_reg.wreg[s_reg.ridx];
        res = 8'h00;
        rd = 32'h0000_0000;
        wd = bus_i.hwdata;
        s_next = s_reg;
        s_next.sleep_pulse = 1'b0;
        s_next.wdog_pulse = 1'b0;
        // write data phase
        if (s_reg.ap_valid && s_reg.ap_write) begin
            case (s_reg.ap_addr)
                bitexec_pkg::A_CMD: begin
                    // a command while busy is dropped and flagged
                    if (s_reg.st == bitexec_pkg::st_idle) begin
                        s_next.op = bitexec_pkg::op_e'(
                            wd[bitexec_pkg::CMD_OP_LSB +: 5]);
                        s_next.ridx = wd[bitexec_pkg::CMD_REG_LSB +: WIDX];
                        s_next.bsel = wd[bitexec_pkg::CMD_BIT_LSB +: 3];
                        s_next.pidx = wd[bitexec_pkg::CMD_IO_LSB +: PIDX];
                        s_next.cnt = op_cycles(s_next.op);
                        s_next.st = bitexec_pkg::st_exec;
                        s_next.last_cmd = wd;
                    end else begin
                        s_next.overrun = 1'b1;
                    end
                end
                bitexec_pkg::A_FLAGS: s_next.flags = wd[7:0];
                bitexec_pkg::A_STATE: begin
                    if (wd[bitexec_pkg::ST_OVR_BIT]) begin
                        s_next.overrun = 1'b0;
                    end
                end
                bitexec_pkg::A_SEL: begin
                    s_next.sel_w = wd[WIDX-1:0];
                    s_next.sel_io = wd[bitexec_pkg::SEL_IO_LSB +: PIDX];
                end
                bitexec_pkg::A_WREG: s_next.wreg[s_reg.sel_w] = wd[7:0];
                bitexec_pkg::A_IOREG: s_next.ioreg[s_reg.sel_io] = wd[7:0];
                default: ;
            endcase
        end
        // execution; effects land on the last busy cycle
        if (s_reg.st == bitexec_pkg::st_exec) begin
            if (s_reg.cnt == 2'h1) begin
                s_next.st = bitexec_pkg::st_idle;
                case (s_reg.op)
                    bitexec_pkg::bit_store_op:
                        s_next.flags[bitexec_pkg::FLAG_T] = w[s_reg.bsel];
                    bitexec_pkg::bit_load_op:
                        s_next.wreg[s_reg.ridx][s_reg.bsel] =
                            s_reg.flags[bitexec_pkg::FLAG_T];
                    bitexec_pkg::io_bit_set_op:
                        s_next.ioreg[s_reg.pidx][s_reg.bsel] = 1'b1;
                    bitexec_pkg::io_bit_clear_op:
                        s_next.ioreg[s_reg.pidx][s_reg.bsel] = 1'b0;
                    bitexec_pkg::rotate_left_carry_op,
                    bitexec_pkg::rotate_right_carry_op: begin
                        if (s_reg.op == bitexec_pkg::rotate_left_carry_op) begin
                            res = {w[6:0], s_reg.flags[bitexec_pkg::FLAG_C]};
                            s_next.flags[bitexec_pkg::FLAG_C] = w[7];
                        end else begin
                            res = {s_reg.flags[bitexec_pkg::FLAG_C], w[7:1]};
                            s_next.flags[bitexec_pkg::FLAG_C] = w[0];
                        end
                        s_next.wreg[s_reg.ridx] = res;
                        s_next.flags[bitexec_pkg::FLAG_Z] = (res == 8'h00);
                        s_next.flags[bitexec_pkg::FLAG_N] = res[7];
                        // overflow is negative xor the new carry
                        s_next.flags[bitexec_pkg::FLAG_V] =
                            res[7] ^ s_next.flags[bitexec_pkg::FLAG_C];
                    end
                    bitexec_pkg::overflow_set_op:
                        s_next.flags[bitexec_pkg::FLAG_V] = 1'b1;
                    bitexec_pkg::overflow_clear_op:
                        s_next.flags[bitexec_pkg::FLAG_V] = 1'b0;
                    bitexec_pkg::half_carry_set_op:
                        s_next.flags[bitexec_pkg::FLAG_H] = 1'b1;
                    bitexec_pkg::half_carry_clear_op:
                        s_next.flags[bitexec_pkg::FLAG_H] = 1'b0;
                    bitexec_pkg::signed_flag_set_op:
                        s_next.flags[bitexec_pkg::FLAG_S] = 1'b1;
                    bitexec_pkg::signed_flag_clear_op:
                        s_next.flags[bitexec_pkg::FLAG_S] = 1'b0;
                    bitexec_pkg::carry_set_op:
                        s_next.flags[bitexec_pkg::FLAG_C] = 1'b1;
                    bitexec_pkg::carry_clear_op:
                        s_next.flags[bitexec_pkg::FLAG_C] = 1'b0;
                    bitexec_pkg::negative_set_op:
                        s_next.flags[bitexec_pkg::FLAG_N] = 1'b1;
                    bitexec_pkg::negative_clear_op:
                        s_next.flags[bitexec_pkg::FLAG_N] = 1'b0;
                    bitexec_pkg::zero_set_op:
                        s_next.flags[bitexec_pkg::FLAG_Z] = 1'b1;
                    bitexec_pkg::zero_clear_op:
                        s_next.flags[bitexec_pkg::FLAG_Z] = 1'b0;
                    bitexec_pkg::transfer_set_op:
                        s_next.flags[bitexec_pkg::FLAG_T] = 1'b1;
                    bitexec_pkg::transfer_clear_op:
                        s_next.flags[bitexec_pkg::FLAG_T] = 1'b0;
                    bitexec_pkg::int_enable_op:
                        s_next.flags[bitexec_pkg::FLAG_I] = 1'b1;
                    bitexec_pkg::int_disable_op:
                        s_next.flags[bitexec_pkg::FLAG_I] = 1'b0;
                    bitexec_pkg::sleep_op:
                        s_next.sleep_pulse = 1'b1;
                    bitexec_pkg::watchdog_restart_op: begin
                        s_next.wdog_pulse = 1'b1;
                        s_next.wdog_cnt = s_reg.wdog_cnt + 8'h01;
                    end
                    default: ; // no-op and unknown codes
                endcase
            end else begin
                s_next.cnt = s_reg.cnt - 2'h1;
            end
        end
        s_next.busy = (s_next.st == bitexec_pkg::st_exec);
        // read data phase: one wait state so reads see settled writes
        s_next.hready = 1'b1;
        if (s_reg.rd_pend) begin
            case (s_reg.ap_addr)
                bitexec_pkg::A_CMD: rd = s_reg.last_cmd;
                bitexec_pkg::A_FLAGS: rd[7:0] = s_reg.flags;
                bitexec_pkg::A_STATE: begin
                    rd[bitexec_pkg::ST_BUSY_BIT] = s_reg.busy;
                    rd[bitexec_pkg::ST_OVR_BIT] = s_reg.overrun;
                    rd[bitexec_pkg::ST_WDOG_LSB +: 8] = s_reg.wdog_cnt;
                end
                bitexec_pkg::A_SEL: begin
                    rd[WIDX-1:0] = s_reg.sel_w;
                    rd[bitexec_pkg::SEL_IO_LSB +: PIDX] = s_reg.sel_io;
                end
                bitexec_pkg::A_WREG: rd[7:0] = s_reg.wreg[s_reg.sel_w];
                bitexec_pkg::A_IOREG: rd[7:0] = s_reg.ioreg[s_reg.sel_io];
                default: rd = 32'h0000_0000;
            endcase
            s_next.hrdata = rd;
            s_next.rd_pend = 1'b0;
        end
        // address phase capture
        s_next.ap_valid = bus_i.hsel && bus_i.hready &&
            (bus_i.htrans == bitexec_pkg::HTRANS_NONSEQ);
        s_next.ap_write = bus_i.hwrite;
        s_next.ap_addr = bus_i.haddr[7:0];
        if (s_next.ap_valid && !bus_i.hwrite) begin
            s_next.rd_pend = 1'b1;
            s_next.hready = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_reg <= '0;
            s_reg.flags <= bitexec_pkg::FLAGS_RST;
            s_reg.hready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from state flops, except hresp which is tied low
    assign bus_o = '{hrdata: s_reg.hrdata, hreadyout: s_reg.hready,
                     hresp: 1'b0};
    assign busy_o = s_reg.busy;
    assign sleep_req_o = s_reg.sleep_pulse;
    assign wdog_restart_o = s_reg.wdog_pulse;
    assign status_o = s_reg.flags;

    // assertion helpers
    logic fire;
    logic quiet;
    logic [7:0] flags_q;
    logic [7:0] wsel;
    logic src_bit;
    logic io_bit;
    logic [7:0] rotl_res;
    logic [7:0] rotr_res;
    assign fire = (s_reg.st == bitexec_pkg::st_exec) && (s_reg.cnt == 2'h1);
    assign quiet = !(s_reg.ap_valid && s_reg.ap_write);
    assign flags_q = s_reg.flags;
    assign wsel = s_reg.wreg[s_reg.ridx];
    assign src_bit = wsel[s_reg.bsel];
    assign io_bit = s_reg.ioreg[s_reg.pidx][s_reg.bsel];
    assign rotl_res = {wsel[6:0], flags_q[bitexec_pkg::FLAG_C]};
    assign rotr_res = {flags_q[bitexec_pkg::FLAG_C], wsel[7:1]};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_bit_store;
        fire && quiet && s_reg.op == bitexec_pkg::bit_store_op |=>
            flags_q[bitexec_pkg::FLAG_T] == $past(src_bit) &&
            flags_q[5:0] == $past(flags_q[5:0]);
    endproperty
    a_bit_store: assert property (p_bit_store) else $error("store");
    property p_bit_load;
        fire && quiet && s_reg.op == bitexec_pkg::bit_load_op |=>
            src_bit == $past(flags_q[bitexec_pkg::FLAG_T]) &&
            flags_q == $past(flags_q);
    endproperty
    a_bit_load: assert property (p_bit_load) else $error("load");
    property p_io_set;
        $rose(busy_o) && s_reg.op == bitexec_pkg::io_bit_set_op |->
            busy_o [*2] ##1 (!busy_o && io_bit);
    endproperty
    a_io_set: assert property (p_io_set) else $error("io set bad");
    property p_io_clear;
        $rose(busy_o) && s_reg.op == bitexec_pkg::io_bit_clear_op |->
            busy_o [*2] ##1 (!busy_o && !io_bit);
    endproperty
    a_io_clear: assert property (p_io_clear) else $error("io clear");
    property p_rot_left;
        fire && quiet && s_reg.op == bitexec_pkg::rotate_left_carry_op |=>
            wsel == $past(rotl_res) &&
            flags_q[bitexec_pkg::FLAG_C] == $past(wsel[7]) &&
            flags_q[bitexec_pkg::FLAG_Z] == (wsel == 8'h00);
    endproperty
    a_rot_left: assert property (p_rot_left) else $error("rot left");
    property p_rot_right;
        fire && quiet && s_reg.op == bitexec_pkg::rotate_right_carry_op |=>
            wsel == $past(rotr_res) &&
            flags_q[bitexec_pkg::FLAG_C] == $past(wsel[0]) &&
            flags_q[bitexec_pkg::FLAG_N] == wsel[7];
    endproperty
    a_rot_right: assert property (p_rot_right) else $error("right");
    property p_ovf_set;
        fire && quiet && s_reg.op == bitexec_pkg::overflow_set_op |=>
            flags_q == ($past(flags_q) | 8'h08);
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("ovf set");
    property p_half_clear;
        fire && quiet && s_reg.op == bitexec_pkg::half_carry_clear_op |=>
            flags_q == ($past(flags_q) & 8'hdf);
    endproperty
    a_half_clear: assert property (p_half_clear) else $error("h clr");
    property p_sgn_set;
        fire && quiet && s_reg.op == bitexec_pkg::signed_flag_set_op |=>
            flags_q == ($past(flags_q) | 8'h10);
    endproperty
    a_sgn_set: assert property (p_sgn_set) else $error("s set");
    property p_sleep;
        $rose(busy_o) && s_reg.op == bitexec_pkg::sleep_op |->
            (busy_o && !sleep_req_o) [*3] ##1 (!busy_o && sleep_req_o);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep timing");
    property p_wdog;
        $rose(busy_o) && s_reg.op == bitexec_pkg::watchdog_restart_op |->
            ##1 wdog_restart_o ##1 !wdog_restart_o;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog pulse");
    property p_one_cycle;
        $rose(busy_o) && op_cycles(s_reg.op) == bitexec_pkg::CYC_ONE |->
            ##1 !busy_o;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("length");

    c_io_set: cover property (fire && s_reg.op == bitexec_pkg::io_bit_set_op);
    c_sleep: cover property (sleep_req_o);
    c_rot_left: cover property (
        fire && s_reg.op == bitexec_pkg::rotate_left_carry_op);
    c_overrun: cover property ($rose(s_reg.overrun));
endmodule
`default_nettype wire

// ---- rtl/bitexec_pkg.sv ----
// Purpose: constants, op codes and bus carriers of the bit/flag executor
// Assumes: 32-bit AHB-Lite register bus, 10 MHz core clock
// Notes: flag positions follow the usual status_register layout
`default_nettype none
package bitexec_pkg;
    // register byte offsets
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_FLAGS = 8'h04;
    localparam logic [7:0] A_STATE = 8'h08;
    localparam logic [7:0] A_SEL = 8'h0c;
    localparam logic [7:0] A_WREG = 8'h10;
    localparam logic [7:0] A_IOREG = 8'h14;
    // command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_REG_LSB = 8;
    localparam int CMD_BIT_LSB = 16;
    localparam int CMD_IO_LSB = 24;
    // state and select register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_OVR_BIT = 1;
    localparam int ST_WDOG_LSB = 8;
    localparam int SEL_IO_LSB = 8;
    // status_register bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    // execution lengths in core cycles, and the AHB NONSEQ transfer code
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_IO = 2'h2;
    localparam logic [1:0] CYC_SLEEP = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [4:0] {
        nop_op, bit_store_op, bit_load_op, io_bit_set_op, io_bit_clear_op,
        rotate_left_carry_op, rotate_right_carry_op,
        overflow_set_op, overflow_clear_op, half_carry_set_op,
        half_carry_clear_op, signed_flag_set_op, signed_flag_clear_op,
        carry_set_op, carry_clear_op, negative_set_op, negative_clear_op,
        zero_set_op, zero_clear_op, transfer_set_op, transfer_clear_op,
        int_enable_op, int_disable_op, sleep_op, watchdog_restart_op
    } op_e;

    typedef enum logic {st_idle, st_exec} exec_e;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ahb_in_s;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ahb_out_s;
endpackage
`default_nettype wire

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench for the bit/flag executor over its bus
// Assumes: hready fed back from hreadyout; single word transfers only
// Notes: outputs are read at the edge, before that edge's updates land
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk_i;
    logic rst_b_i;
    bitexec_pkg::ahb_in_s m;
    bitexec_pkg::ahb_in_s bus_in;
    bitexec_pkg::ahb_out_s bus_out;
    logic busy_o;
    logic sleep_req_o;
    logic wdog_restart_o;
    logic [7:0] status_o;
    logic sleep_seen;
    logic wd_seen;
    int n_errors = 0;
    int checked = 0;
    int n_busy;

    bit_flag_instr_exec u_bit_flag_instr_exec (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_in), .bus_o(bus_out),
        .busy_o(busy_o), .sleep_req_o(sleep_req_o),
        .wdog_restart_o(wdog_restart_o), .status_o(status_o));

    // single slave, so its ready is the bus ready
    always_comb begin
        bus_in = m;
        bus_in.hready = bus_out.hreadyout;
    end

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic check32(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // bounded wait for hready high at an edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (bus_out.hreadyout !== 1'b1 && n < 20);
        check32({31'h0, bus_out.hreadyout}, 32'h1, "hready");
    endtask

    task automatic bus_xfer(input logic w, input logic [7:0] a,
                            input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        m.hsel <= 1'b1;
        m.htrans <= bitexec_pkg::HTRANS_NONSEQ;
        m.haddr <= {24'h0, a};
        m.hwrite <= w;
        m.hsize <= 3'h2;
        wait_ready();
        m.hsel <= 1'b0;
        m.htrans <= 2'h0;
        m.hwdata <= w ? d : 32'h0;
        wait_ready();
        q = bus_out.hrdata;
        check32({31'h0, bus_out.hresp}, 32'h0, "okay response");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        logic [31:0] q;
        bus_xfer(1'b0, a, 32'h0, q);
        check32(q, exp, what);
    endtask

    // issue one op, count busy cycles and note the completion pulses
    task automatic run_op(input bitexec_pkg::op_e op, input logic [4:0] r,
                          input logic [2:0] b, input logic [4:0] io,
                          input int exp_n, input string what);
        wr(bitexec_pkg::A_CMD, {3'h0, io, 5'h0, b, 3'h0, r, 3'h0, op});
        n_busy = 0;
        do begin
            @(posedge clk_i);
            if (busy_o === 1'b1) n_busy++;
        end while (busy_o === 1'b1 && n_busy < 10);
        sleep_seen = sleep_req_o;
        wd_seen = wdog_restart_o;
        check32(32'(n_busy), 32'(exp_n), what);
    endtask

    task automatic t_reset();
        check32({24'h0, status_o}, 32'h0, "status after reset");
        rd_chk(bitexec_pkg::A_FLAGS, 32'h0, "flags after reset");
        rd_chk(bitexec_pkg::A_STATE, 32'h0, "state after reset");
        wr(8'h20, 32'hffff_ffff);
        rd_chk(8'h20, 32'h0, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_bit_xfer();
        wr(bitexec_pkg::A_SEL, 32'h3);
        wr(bitexec_pkg::A_WREG, 32'h20);
        wr(bitexec_pkg::A_FLAGS, 32'hbf);
        run_op(bitexec_pkg::bit_store_op, 5'h3, 3'h5, 5'h0, 1, "store");
        check32({24'h0, status_o}, 32'hff, "store one");
        run_op(bitexec_pkg::bit_load_op, 5'h3, 3'h0, 5'h0, 1, "load");
        rd_chk(bitexec_pkg::A_WREG, 32'h21, "load bit");
        check32({24'h0, status_o}, 32'hff, "load flags");
        run_op(bitexec_pkg::bit_store_op, 5'h3, 3'h1, 5'h0, 1, "store");
        check32({24'h0, status_o}, 32'hbf, "store zero");
        $display("test bit transfer done");
    endtask

    task automatic t_io();
        wr(bitexec_pkg::A_SEL, 32'h0500);
        rd_chk(bitexec_pkg::A_SEL, 32'h0500, "select readback");
        wr(bitexec_pkg::A_IOREG, 32'h0f);
        wr(bitexec_pkg::A_FLAGS, 32'h5a);
        run_op(bitexec_pkg::io_bit_set_op, 5'h0, 3'h7, 5'h5, 2, "sbit");
        rd_chk(bitexec_pkg::A_IOREG, 32'h8f, "io set");
        run_op(bitexec_pkg::io_bit_clear_op, 5'h0, 3'h0, 5'h5, 2, "cb");
        rd_chk(bitexec_pkg::A_IOREG, 32'h8e, "io clear");
        check32({24'h0, status_o}, 32'h5a, "io flags");
        $display("test io bits done");
    endtask

    // s and h preset: rotates must leave them alone
    task automatic t_rotate();
        wr(bitexec_pkg::A_SEL, 32'h2);
        wr(bitexec_pkg::A_WREG, 32'h80);
        wr(bitexec_pkg::A_FLAGS, 32'h30);
        run_op(bitexec_pkg::rotate_left_carry_op, 5'h2, 3'h0, 5'h0, 1,
               "rotate left");
        rd_chk(bitexec_pkg::A_WREG, 32'h00, "left value");
        check32({24'h0, status_o}, 32'h3b, "left flags");
        run_op(bitexec_pkg::rotate_right_carry_op, 5'h2, 3'h0, 5'h0, 1,
               "rotate right");
        rd_chk(bitexec_pkg::A_WREG, 32'h80, "right value");
        check32({24'h0, status_o}, 32'h3c, "right flags");
        $display("test rotate done");
    endtask

    // table indexed by flag position c z n v s h t i
    task automatic t_flag_ops();
        bitexec_pkg::op_e set_ops[8];
        bitexec_pkg::op_e clr_ops[8];
        set_ops = '{bitexec_pkg::carry_set_op, bitexec_pkg::zero_set_op,
            bitexec_pkg::negative_set_op, bitexec_pkg::overflow_set_op,
            bitexec_pkg::signed_flag_set_op, bitexec_pkg::half_carry_set_op,
            bitexec_pkg::transfer_set_op, bitexec_pkg::int_enable_op};
        clr_ops = '{bitexec_pkg::carry_clear_op, bitexec_pkg::zero_clear_op,
            bitexec_pkg::negative_clear_op, bitexec_pkg::overflow_clear_op,
            bitexec_pkg::signed_flag_clear_op,
            bitexec_pkg::half_carry_clear_op,
            bitexec_pkg::transfer_clear_op, bitexec_pkg::int_disable_op};
        for (int i = 0; i < 8; i++) begin
            wr(bitexec_pkg::A_FLAGS, 32'h0);
            run_op(set_ops[i], 5'h0, 3'h0, 5'h0, 1, "set");
            check32({24'h0, status_o}, 32'h1 << i, "set");
            wr(bitexec_pkg::A_FLAGS, 32'hff);
            run_op(clr_ops[i], 5'h0, 3'h0, 5'h0, 1, "clr");
            check32({24'h0, status_o}, 32'hff ^ (32'h1 << i), "clr");
        end
        run_op(bitexec_pkg::nop_op, 5'h0, 3'h0, 5'h0, 1, "nop");
        // the last clear of the loop left the interrupt flag low
        check32({24'h0, status_o}, 32'h7f, "nop flags");
        $display("test flag ops done");
    endtask

    task automatic t_sleep_wdog();
        logic [31:0] st;
        wr(bitexec_pkg::A_FLAGS, 32'ha5);
        run_op(bitexec_pkg::sleep_op, 5'h0, 3'h0, 5'h0, 3, "sleep");
        check32({30'h0, sleep_seen, wd_seen}, 32'h2, "sleep pulse");
        check32({24'h0, status_o}, 32'ha5, "sleep flags");
        bus_xfer(1'b0, bitexec_pkg::A_STATE, 32'h0, st);
        run_op(bitexec_pkg::watchdog_restart_op, 5'h0, 3'h0, 5'h0, 1,
               "wdog restart");
        check32({30'h0, sleep_seen, wd_seen}, 32'h1, "wdog pulse");
        check32({24'h0, status_o}, 32'ha5, "wdog flags");
        rd_chk(bitexec_pkg::A_STATE, {16'h0, st[15:8] + 8'h1, 8'h0},
               "wdog count");
        $display("test sleep and watchdog done");
    endtask

    // a command written while one still runs is dropped and flagged
    task automatic t_overrun();
        logic [31:0] st;
        logic [31:0] cmd;
        cmd = {27'h0, bitexec_pkg::sleep_op};
        bus_xfer(1'b0, bitexec_pkg::A_STATE, 32'h0, st);
        wr(bitexec_pkg::A_CMD, cmd);
        rd_chk(bitexec_pkg::A_STATE, {st[31:2], 2'b01}, "busy bit");
        wr(bitexec_pkg::A_CMD, cmd);
        wr(bitexec_pkg::A_CMD, {27'h0, bitexec_pkg::watchdog_restart_op});
        rd_chk(bitexec_pkg::A_STATE, {st[31:2], 2'b10}, "overrun set");
        rd_chk(bitexec_pkg::A_CMD, cmd, "last command");
        wr(bitexec_pkg::A_STATE, 32'h2);
        rd_chk(bitexec_pkg::A_STATE, {st[31:2], 2'b00}, "overrun cleared");
        $display("test overrun done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog: fires after 4000 cycles; the whole run needs well under that
    initial begin
        #400000;
        n_errors++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        tally_and_finish();
    end

    initial begin
        m = '0;
        rst_b_i = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_bit_xfer();
        t_io();
        t_rotate();
        t_flag_ops();
        t_sleep_wdog();
        t_overrun();
        tally_and_finish();
    end
endmodule
`default_nettype wire
